// ===== hw/conv_done_ctrl.sv
// Conversion-done indicator: held low in direct mode, timed low pulse in automatic mode.
// Assumes single-cycle event pulses from the converter sequencer, synchronous to clk.
module conv_done_ctrl #(
    parameter int PULSE_CYC = pins_pkg::DONE_PULSE_CYC
) (
    input wire logic clk, // 200 MHz clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic soft_clr, // Hardware reset from the reset pin
    input wire logic auto_mode, // 1 = automatic mode, 0 = direct mode
    input wire logic conv_finish, // Direct-mode conversion finished pulse
    input wire logic cycle_finish, // Automatic-mode conversion cycle finished pulse
    input wire logic data_read, // Result read, releases the held indicator
    output logic conv_done_n // Conversion-done indicator, active low
);

    localparam int CNT_W = $clog2(PULSE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    pins_pkg::done_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // ========================================================
    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (soft_clr)
        begin
            state_d = pins_pkg::DONE_IDLE;
            cnt_d = CNT_ZERO;
        end
        else
        begin
            case (state_q)
                pins_pkg::DONE_IDLE:
                begin
                    if (!auto_mode && conv_finish)
                        state_d = pins_pkg::DONE_HELD;
                    else if (auto_mode && cycle_finish)
                    begin
                        state_d = pins_pkg::DONE_PULSE;
                        cnt_d = CNT_LOAD;
                    end
                end
                pins_pkg::DONE_HELD:
                begin
                    if (auto_mode && cycle_finish)
                    begin
                        state_d = pins_pkg::DONE_PULSE;
                        cnt_d = CNT_LOAD;
                    end
                    else if (data_read || auto_mode)
                        state_d = pins_pkg::DONE_IDLE;
                end
                pins_pkg::DONE_PULSE:
                begin
                    if (cnt_q == CNT_ZERO)
                        state_d = pins_pkg::DONE_IDLE;
                    else
                        cnt_d = cnt_q - CNT_W'(1);
                end
                default:
                begin
                    state_d = pins_pkg::DONE_IDLE;
                    cnt_d = CNT_ZERO;
                end
            endcase
        end
    end

    // State, counter and registered pin
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= pins_pkg::DONE_IDLE;
            cnt_q <= CNT_ZERO;
            conv_done_n <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            conv_done_n <= (state_d == pins_pkg::DONE_IDLE);
        end
    end

    // ========================================================
    // Assertions
    logic [CNT_W-1:0] pulse_len_q;

    // Length of the current automatic-mode pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pulse_len_q <= CNT_ZERO;
        else if (state_q == pins_pkg::DONE_PULSE)
            pulse_len_q <= pulse_len_q + CNT_W'(1);
        else
            pulse_len_q <= CNT_ZERO;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_DIRECT_LOW: assert property (
        (state_q == pins_pkg::DONE_IDLE) && !auto_mode && conv_finish && !soft_clr
        |=> !conv_done_n && (state_q == pins_pkg::DONE_HELD))
        else $error("direct mode: done indicator not low after conversion");
    AST_AUTO_START: assert property (
        (state_q == pins_pkg::DONE_IDLE) && auto_mode && cycle_finish && !soft_clr
        |=> !conv_done_n ##1 !conv_done_n)
        else $error("automatic mode: done pulse did not start");
    AST_AUTO_WIDTH: assert property (
        $past(state_q) == pins_pkg::DONE_PULSE && state_q != pins_pkg::DONE_PULSE && !$past(soft_clr)
        |-> $past(pulse_len_q) == CNT_LOAD && conv_done_n)
        else $error("automatic mode: done pulse has wrong width");
    AST_IDLE_HIGH: assert property (
        conv_done_n && !conv_finish && !cycle_finish |=> conv_done_n)
        else $error("done indicator fell without a finish event");

    COV_AUTO_PULSE: cover property (state_q == pins_pkg::DONE_PULSE ##1 state_q == pins_pkg::DONE_IDLE);
    COV_DIRECT_HELD: cover property (state_q == pins_pkg::DONE_HELD ##1 state_q == pins_pkg::DONE_IDLE);

endmodule

// ===== hw/pins_pkg.sv
// Shared constants for the indicator and trigger pin block.
// Assumes a single 200 MHz clock and an AXI4-Lite register slave with 32-bit data.
package pins_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] WORD_MASK = 8'hFC;

    // ========================================================
    // Control register fields
    localparam int CTRL_REF_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_EXTTRIG_BIT = 2;
    localparam int CTRL_DACSEL_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_FF07;

    // ========================================================
    // Status register fields
    localparam int STAT_ALARM_LSB = 0;
    localparam int STAT_DONE_BIT = 4;
    localparam int STAT_GALARM_BIT = 5;
    localparam int STAT_HWRST_BIT = 6;

    // ========================================================
    // Interrupt status and mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_DACLD = 2;
    localparam int IRQ_CONV = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // ========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DONE_PULSE_NS = 2000;
    localparam int DONE_PULSE_CYC = (DONE_PULSE_NS * 1000) / CLK_PERIOD_PS;
    localparam int NUM_DAC = 8;
    localparam int NUM_ALARM = 4;

    // Conversion-done indicator states
    typedef enum logic [2:0]
    {
        DONE_IDLE = 3'h1,
        DONE_HELD = 3'h2,
        DONE_PULSE = 3'h4
    } done_state_t;

endpackage

// ===== hw/status_and_trigger_pins.sv
// Indicator and trigger pins of an analog monitor, with an AXI4-Lite register slave.
// Assumes all pin inputs are synchronous to clk and converter events are one-cycle pulses.
// What this block does
// - Alarm pin low while any input out of range
// - Direct mode: done pin low after conversion
// - Automatic mode: 2 us low done pulse
// - Deactivated done pin stays high
// - Load trigger rise updates selected DACs together
// - Reference level follows its configuration bit
// - External mode: trigger rise starts conversion
// - Low reset pin performs hardware reset
module status_and_trigger_pins #(
    parameter int ADDR_W = pins_pkg::ADDR_W,
    parameter int NUM_DAC = pins_pkg::NUM_DAC,
    parameter int NUM_ALARM = pins_pkg::NUM_ALARM,
    parameter int DONE_PULSE_CYC = pins_pkg::DONE_PULSE_CYC
) (
    input wire logic clk, // 200 MHz clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [NUM_ALARM-1:0] chan_out_of_range, // Out-of-range flags of the first inputs
    input wire logic conv_finish, // Direct-mode conversion finished pulse
    input wire logic cycle_finish, // Automatic-mode cycle finished pulse
    input wire logic adc_data_read, // Conversion result has been read
    input wire logic dac_sync_load_trig, // External DAC synchronous load trigger pin
    input wire logic convert_trig, // External conversion trigger pin
    input wire logic reset_pin_n, // Hardware reset pin, active low
    output logic global_alarm_n, // Global alarm pin, active low
    output logic conv_done_n, // Conversion-done pin, active low
    output logic [NUM_DAC-1:0] dac_update, // One-cycle load strobe per DAC
    output logic adc_start, // One-cycle start of sampling and conversion
    output logic ref_level_sel, // Internal reference level select
    output logic auto_mode, // Converter automatic mode
    output logic hw_reset_active, // Hardware reset in progress
    output logic irq // Interrupt, active high level
);

    // ========================================================
    // Helpers
    function automatic logic rising(input logic cur, input logic prev);
        rising = cur && !prev;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{strb[i]}};
        m = m & wmask;
        merge = (old & ~m) | (wdat & m);
    endfunction

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        is_reg = ((a[7:0] & pins_pkg::WORD_MASK) == off) && (a >> 8) == '0;
    endfunction

    // ========================================================
    // Registers and pin history
    logic [31:0] ctrl_q;
    logic [pins_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev, irq_clr;
    logic dac_sync_load_trig_q, convert_q, done_n_q;
    logic hw_rst;
    logic aw_full_q, w_full_q, do_write;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] rd_mux;
    logic rd_ok, wr_ok;

    assign hw_rst = !reset_pin_n;
    assign ref_level_sel = ctrl_q[pins_pkg::CTRL_REF_BIT];
    assign auto_mode = ctrl_q[pins_pkg::CTRL_AUTO_BIT];

    // ========================================================
    // AXI4-Lite write channel
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_ok = is_reg(aw_addr_q, pins_pkg::OFF_CTRL) || is_reg(aw_addr_q, pins_pkg::OFF_STATUS)
        || is_reg(aw_addr_q, pins_pkg::OFF_IRQ_STAT) || is_reg(aw_addr_q, pins_pkg::OFF_IRQ_MASK);

    // Address and data are held independently until both are present
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (do_write)
                aw_full_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (do_write)
                w_full_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pins_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? pins_pkg::RESP_OKAY : pins_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control register, cleared while the reset pin is low
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ctrl_q <= pins_pkg::CTRL_RESET;
        else if (hw_rst)
            ctrl_q <= pins_pkg::CTRL_RESET;
        else if (do_write && is_reg(aw_addr_q, pins_pkg::OFF_CTRL))
            ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q, pins_pkg::CTRL_WMASK);
    end

    // ========================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    // Read data selection
    always_comb
    begin
        rd_mux = '0;
        rd_ok = 1'b1;
        if (is_reg(s_axi_araddr, pins_pkg::OFF_CTRL))
            rd_mux = ctrl_q;
        else if (is_reg(s_axi_araddr, pins_pkg::OFF_STATUS))
        begin
            rd_mux[pins_pkg::STAT_ALARM_LSB +: NUM_ALARM] = chan_out_of_range;
            rd_mux[pins_pkg::STAT_DONE_BIT] = !conv_done_n;
            rd_mux[pins_pkg::STAT_GALARM_BIT] = !global_alarm_n;
            rd_mux[pins_pkg::STAT_HWRST_BIT] = hw_reset_active;
        end
        else if (is_reg(s_axi_araddr, pins_pkg::OFF_IRQ_STAT))
            rd_mux[pins_pkg::IRQ_W-1:0] = irq_stat_q;
        else if (is_reg(s_axi_araddr, pins_pkg::OFF_IRQ_MASK))
            rd_mux[pins_pkg::IRQ_W-1:0] = irq_mask_q;
        else
            rd_ok = 1'b0;
    end

    // Read response
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pins_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? pins_pkg::RESP_OKAY : pins_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ========================================================
    // Pin logic
    // Trigger and done pin history for edge detection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dac_sync_load_trig_q <= 1'b0;
            convert_q <= 1'b0;
            done_n_q <= 1'b1;
        end
        else
        begin
            dac_sync_load_trig_q <= dac_sync_load_trig;
            convert_q <= convert_trig;
            done_n_q <= conv_done_n;
        end
    end

    // Alarm, DAC load, conversion start and reset indication
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            global_alarm_n <= 1'b1;
            dac_update <= '0;
            adc_start <= 1'b0;
            hw_reset_active <= 1'b0;
        end
        else
        begin
            global_alarm_n <= !(|chan_out_of_range);
            hw_reset_active <= hw_rst;
            if (!hw_rst && rising(dac_sync_load_trig, dac_sync_load_trig_q))
                dac_update <= ctrl_q[pins_pkg::CTRL_DACSEL_LSB +: NUM_DAC];
            else
                dac_update <= '0;
            adc_start <= !hw_rst && ctrl_q[pins_pkg::CTRL_EXTTRIG_BIT]
                && rising(convert_trig, convert_q);
        end
    end

    conv_done_ctrl #(
        .PULSE_CYC(DONE_PULSE_CYC)
    ) u_done (
        .clk(clk),
        .reset(reset),
        .soft_clr(hw_rst),
        .auto_mode(auto_mode),
        .conv_finish(conv_finish),
        .cycle_finish(cycle_finish),
        .data_read(adc_data_read),
        .conv_done_n(conv_done_n)
    );

    // ========================================================
    // Interrupts: sticky events, write one to clear, set wins
    always_comb
    begin
        irq_ev = '0;
        irq_ev[pins_pkg::IRQ_ALARM] = (|chan_out_of_range) && global_alarm_n;
        irq_ev[pins_pkg::IRQ_DONE] = !conv_done_n && done_n_q;
        irq_ev[pins_pkg::IRQ_DACLD] = rising(dac_sync_load_trig, dac_sync_load_trig_q);
        irq_ev[pins_pkg::IRQ_CONV] = ctrl_q[pins_pkg::CTRL_EXTTRIG_BIT] && rising(convert_trig, convert_q);
        irq_clr = '0;
        if (do_write && is_reg(aw_addr_q, pins_pkg::OFF_IRQ_STAT) && w_strb_q[0])
            irq_clr = w_data_q[pins_pkg::IRQ_W-1:0];
    end

    // Interrupt status, mask and output
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_stat_q <= pins_pkg::IRQ_RESET;
            irq_mask_q <= pins_pkg::IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_q <= hw_rst ? pins_pkg::IRQ_RESET : ((irq_stat_q & ~irq_clr) | irq_ev);
            if (hw_rst)
                irq_mask_q <= pins_pkg::IRQ_RESET;
            else if (do_write && is_reg(aw_addr_q, pins_pkg::OFF_IRQ_MASK) && w_strb_q[0])
                irq_mask_q <= w_data_q[pins_pkg::IRQ_W-1:0];
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_GLOBAL_ALARM: assert property (
        ##1 (global_alarm_n == !$past(|chan_out_of_range)))
        else $error("global alarm does not follow out-of-range inputs");
    AST_DAC_LOAD: assert property (
        reset_pin_n && dac_sync_load_trig && !dac_sync_load_trig_q
        |=> dac_update == $past(ctrl_q[pins_pkg::CTRL_DACSEL_LSB +: NUM_DAC]) ##1 dac_update == '0)
        else $error("selected DACs not loaded together on trigger rise");
    AST_DAC_QUIET: assert property (
        !(dac_sync_load_trig && !dac_sync_load_trig_q) |=> dac_update == '0)
        else $error("DAC load without trigger rise");
    AST_REF_LEVEL: assert property (
        do_write && reset_pin_n && is_reg(aw_addr_q, pins_pkg::OFF_CTRL) && w_strb_q[0]
        |=> ref_level_sel == $past(w_data_q[pins_pkg::CTRL_REF_BIT]))
        else $error("reference level does not follow configuration write");
    AST_CONV_START: assert property (
        reset_pin_n && ctrl_q[pins_pkg::CTRL_EXTTRIG_BIT] && convert_trig && !convert_q
        |=> adc_start ##1 !adc_start)
        else $error("conversion not started on trigger rise");
    AST_CONV_NOEXT: assert property (
        !ctrl_q[pins_pkg::CTRL_EXTTRIG_BIT] |=> !adc_start)
        else $error("conversion started outside external trigger mode");
    AST_HW_RESET: assert property (
        !reset_pin_n |=> ctrl_q == pins_pkg::CTRL_RESET && irq_mask_q == pins_pkg::IRQ_RESET && hw_reset_active)
        else $error("reset pin did not reset the block");
    AST_IRQ_LEVEL: assert property (
        (|(irq_stat_q & irq_mask_q)) |=> irq)
        else $error("interrupt not raised for unmasked status");

    COV_DAC_LOAD: cover property (dac_update != '0);
    COV_EXT_CONV: cover property (adc_start ##[1:50] !global_alarm_n);

endmodule

// ===== tb/host_pins.sv
// Host-side model: drives the monitor's event, trigger and reset pins.
// Assumes clk is the block clock; tasks change pins by NBA after a rising edge.
module host_pins (
    input wire logic clk, // Block clock
    output logic [3:0] chan_out_of_range, // Out-of-range flags
    output logic conv_finish, // Direct-mode finish pulse
    output logic cycle_finish, // Auto-mode finish pulse
    output logic adc_data_read, // Result read pulse
    output logic dac_sync_load_trig, // Load trigger pin
    output logic convert_trig, // Conversion trigger pin
    output logic reset_pin_n // Hardware reset pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pin levels, reset pin released
    initial
    begin
        {chan_out_of_range, conv_finish, cycle_finish, adc_data_read} = 7'h00;
        {dac_sync_load_trig, convert_trig, reset_pin_n} = 3'h1;
    end
    // ==========================================
    // Pin tasks
    task automatic set_range(input logic [3:0] v);
        @(posedge clk);
        chan_out_of_range <= v;
    endtask
    // One-cycle event: 0 conversion, 1 cycle, 2 data read
    task automatic pulse(input int k);
        @(posedge clk);
        conv_finish <= (k == 0);
        cycle_finish <= (k == 1);
        adc_data_read <= (k == 2);
        @(posedge clk);
        {conv_finish, cycle_finish, adc_data_read} <= 3'h0;
    endtask
    // Trigger held two cycles so its width is always met: 0 load, 1 convert
    task automatic trig(input int k);
        @(posedge clk);
        dac_sync_load_trig <= (k == 0);
        convert_trig <= (k == 1);
        repeat (2) @(posedge clk);
        {dac_sync_load_trig, convert_trig} <= 2'h0;
    endtask
    task automatic hw_reset(input int n);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the indicator and trigger pin block.
// Assumes host_pins drives the pins; reads are checked from an expectation queue.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 8;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00, upd, last = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wr_r, bv, arr, rv, gal_n, cdn, ast, refs, autom, hwr, irq;
    logic [1:0] bresp, rresp;
    logic [3:0] chan, ws = 4'hF;
    logic cf, cyf, drd, ldt, cvt, rpn;
    logic [33:0] expq[$];
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #2.5 clk = ~clk;
    host_pins host (.clk(clk), .chan_out_of_range(chan), .conv_finish(cf), .cycle_finish(cyf),
        .adc_data_read(drd), .dac_sync_load_trig(ldt), .convert_trig(cvt), .reset_pin_n(rpn));
    status_and_trigger_pins #(.DONE_PULSE_CYC(PC)) uut (.clk(clk), .reset(reset),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .chan_out_of_range(chan), .conv_finish(cf), .cycle_finish(cyf),
        .adc_data_read(drd), .dac_sync_load_trig(ldt), .convert_trig(cvt), .reset_pin_n(rpn),
        .global_alarm_n(gal_n), .conv_done_n(cdn), .dac_update(upd), .adc_start(ast),
        .ref_level_sel(refs), .auto_mode(autom), .hw_reset_active(hwr), .irq(irq));
    // ==========================================
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        expq.push_back(34'(a > pins_pkg::OFF_IRQ_MASK ? pins_pkg::RESP_SLVERR : pins_pkg::RESP_OKAY));
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
        end
        while (!(bv && br));
        br <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end
        while (!(rv && rr));
        rr <= 1'b0;
        @(posedge clk);
    endtask
    // Counts cycles an output is active: 0 load strobe, 1 start strobe, 2 done low
    task automatic cnt(input int k, output int n);
        n = 0;
        repeat (16)
        begin
            @(negedge clk);
            if ((k == 0 && upd !== 8'h00) || (k == 1 && ast === 1'b1) || (k == 2 && cdn === 1'b0)) n++;
            if (k == 0 && upd !== 8'h00) last = upd;
        end
        @(posedge clk);
    endtask
    // Response monitor takes the oldest expectation at each read response and each write response
    always @(posedge clk)
    begin
        if (rv && rr) chk("read", {rresp, rdat}, expq.pop_front());
        if (bv && br) chk("bresp", 34'(bresp), expq.pop_front());
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin
        int n;
        logic [7:0] v;
        void'($urandom(70));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(pins_pkg::OFF_CTRL, 34'h0);
        rd(pins_pkg::OFF_IRQ_MASK, 34'h0);
        rd(8'h10, {pins_pkg::RESP_SLVERR, 32'h0});
        repeat (4)
        begin
            v = 8'($urandom_range(15, 1));
            host.set_range(v[3:0]);
            repeat (3) @(posedge clk);
            chk("alarm_on", 34'(gal_n), 34'h0);
            rd(pins_pkg::OFF_STATUS, {2'h0, 24'h0, 4'h2, v[3:0]});
            host.set_range(4'h0);
            repeat (3) @(posedge clk);
            chk("alarm_off", 34'(gal_n), 34'h1);
        end
        $display("test alarm done");
        wr(pins_pkg::OFF_CTRL, 32'h1);
        chk("ref_hi", 34'(refs), 34'h1);
        wr(pins_pkg::OFF_CTRL, 32'h0);
        chk("ref_lo", 34'(refs), 34'h0);
        host.pulse(0);
        repeat (3) @(posedge clk);
        chk("done_direct", 34'(cdn), 34'h0);
        host.pulse(2);
        repeat (3) @(posedge clk);
        chk("done_release", 34'(cdn), 34'h1);
        wr(pins_pkg::OFF_CTRL, 32'h2);
        chk("auto_on", 34'(autom), 34'h1);
        fork
            host.pulse(1);
            cnt(2, n);
        join
        chk("auto_pulse", 34'(n), 34'(PC));
        chk("auto_idle", {33'h0, cdn}, 34'h1);
        $display("test done pin done");
        v = 8'($urandom_range(255, 1));
        wr(pins_pkg::OFF_CTRL, {16'h0, v, 8'h00});
        fork
            host.trig(0);
            cnt(0, n);
        join
        chk("load_count", 34'(n), 34'h1);
        chk("load_set", 34'(last), 34'(v));
        for (int m = 0; m < 2; m++)
        begin
            wr(pins_pkg::OFF_CTRL, 32'(m * 4));
            fork
                host.trig(1);
                cnt(1, n);
            join
            chk("start", 34'(n), 34'(m));
        end
        $display("test triggers done");
        rd(pins_pkg::OFF_IRQ_STAT, 34'hF);
        wr(pins_pkg::OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_on", 34'(irq), 34'h1);
        wr(pins_pkg::OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_off", 34'(irq), 34'h0);
        rd(pins_pkg::OFF_IRQ_STAT, 34'hE);
        ws <= 4'hE;
        wr(pins_pkg::OFF_IRQ_MASK, 32'hF);
        ws <= 4'hF;
        rd(pins_pkg::OFF_IRQ_MASK, 34'h1);
        wr(8'h10, 32'h3);
        rd(pins_pkg::OFF_CTRL, 34'h4);
        $display("test irq done");
        wr(pins_pkg::OFF_CTRL, 32'h3);
        fork
            host.hw_reset(4);
            begin
                repeat (4) @(posedge clk);
                chk("hw_reset", 34'(hwr), 34'h1);
            end
        join
        rd(pins_pkg::OFF_CTRL, 34'h0);
        rd(pins_pkg::OFF_IRQ_MASK, 34'h0);
        $display("test hw reset done");
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
